// ==== include/gpio_port_pkg.sv ====
// constants and carriers for the 32-pin level and direction port
// assumes a plain register port on the system clock
package gpio_port_pkg;

    localparam int unsigned PIN_COUNT = 32;
    localparam int unsigned ADDR_W    = 12;

    // register offsets (byte addresses)
    localparam logic [ADDR_W-1:0] DRIVE_LEVEL_WORD_OFS      = 12'h0504;
    localparam logic [ADDR_W-1:0] DRIVE_HIGH_STROBE_OFS     = 12'h0508;
    localparam logic [ADDR_W-1:0] DRIVE_LOW_STROBE_OFS      = 12'h050c;
    localparam logic [ADDR_W-1:0] SAMPLED_LEVELS_OFS        = 12'h0510;
    localparam logic [ADDR_W-1:0] LINE_ORIENTATION_WORD_OFS = 12'h0514;
    localparam logic [ADDR_W-1:0] ENABLE_DRIVER_STROBE_OFS  = 12'h0518;
    localparam logic [ADDR_W-1:0] RELEASE_DRIVER_STROBE_OFS = 12'h051c;
    // per-pin setup: base plus four bytes per pin
    localparam logic [ADDR_W-1:0] PER_LINE_SETUP_BASE       = 12'h0700;
    localparam logic [ADDR_W-1:0] PER_LINE_SETUP_LAST       = 12'h077c;
    localparam int unsigned       SETUP_IDX_LSB             = 2;
    localparam int unsigned       SETUP_IDX_W               = 5;

    // per-pin setup field positions
    localparam int unsigned SETUP_DIR_BIT   = 0;
    localparam int unsigned SETUP_INPUT_BIT = 1;

    // reset values
    localparam logic [31:0] DRIVE_LEVEL_RESET = 32'h0000_0000;
    localparam logic [31:0] ORIENT_RESET      = 32'h0000_0000;
    // input buffer disconnect bits: zero means connected
    localparam logic [31:0] INPUT_DISC_RESET  = 32'h0000_0000;
    localparam logic [31:0] ZERO_WORD         = 32'h0000_0000;

    // register port request
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [31:0]       wdata;
        logic              wr;
        logic              rd;
    } reg_req_t;

    // pin bundle toward the pads
    typedef struct packed {
        logic [PIN_COUNT-1:0] level;
        logic [PIN_COUNT-1:0] enable;
    } pin_drive_t;

    // all state of the port
    typedef struct packed {
        logic [PIN_COUNT-1:0] driveLevel;
        logic [PIN_COUNT-1:0] orientation;
        logic [PIN_COUNT-1:0] inputDisc;
        logic [PIN_COUNT-1:0] syncA;
        logic [PIN_COUNT-1:0] syncB;
        logic [PIN_COUNT-1:0] padOut;
        logic [PIN_COUNT-1:0] padOe;
        logic [31:0]          rdata;
    } port_state_t;

endpackage

// ==== design/gpio_port_level_direction.sv ====
// one 32-pin general purpose port: drive level, direction, sampled levels
// assumes pads outside resolve the wire; pin inputs are asynchronous
//
// What this block does
// - set and clear drive reads return level word
// - drive set write raises written ones only
// - drive clear write lowers written ones only
// - direction word resets zero, one means output
// - direction set and clear read direction word
// - direction set write makes ones outputs
// - direction clear write makes ones inputs
// - sampled level valid only with buffer connected
// - per-pin direction bit shares direction word storage
`timescale 1ns/100ps
`default_nettype none

module gpio_port_level_direction
    import gpio_port_pkg::*;
(
    input  wire logic                          mclk,     // system clock, 100 MHz
    input  wire logic                          resetn,   // async reset, active low
    input  wire gpio_port_pkg::reg_req_t       regReq,   // register port request
    output logic [31:0]                        regRdata, // read data, cycle after read
    input  wire logic [gpio_port_pkg::PIN_COUNT-1:0] padIn, // pad input levels
    output logic [gpio_port_pkg::PIN_COUNT-1:0] padOut,  // pad output levels
    output logic [gpio_port_pkg::PIN_COUNT-1:0] padOe    // pad drive enables
);
    import gpio_port_pkg::*;

    port_state_t             state;       // registered state
    port_state_t             next_state;  // next state
    logic [SETUP_IDX_W-1:0]  setupIdx;    // pin index of a setup access
    logic                    setupHit;    // address falls in setup range
    logic [31:0]             setupRead;   // setup word for that pin
    logic [PIN_COUNT-1:0]    sampled;     // gated pin levels

    // decode of the per-pin setup window
    assign setupIdx = regReq.addr[SETUP_IDX_LSB +: SETUP_IDX_W];
    assign setupHit = (regReq.addr >= PER_LINE_SETUP_BASE)
                   && (regReq.addr <= PER_LINE_SETUP_LAST)
                   && (regReq.addr[SETUP_IDX_LSB-1:0] == '0);

    // disconnected buffers read as zero, not a stale level
    assign sampled = state.syncB & ~state.inputDisc;

    // setup word: only direction and buffer bits are kept here
    always_comb
    begin
        setupRead = ZERO_WORD;
        setupRead[SETUP_DIR_BIT]   = state.orientation[setupIdx];
        setupRead[SETUP_INPUT_BIT] = state.inputDisc[setupIdx];
    end

    // next-state logic: register writes, reads, synchroniser, pads
    always_comb
    begin
        next_state = state;
        // two-stage synchroniser; only syncB is read by logic
        next_state.syncA = padIn;
        next_state.syncB = state.syncA;

        // writes: address decode as an if chain
        if (regReq.wr)
        begin
            if (regReq.addr == DRIVE_LEVEL_WORD_OFS)
            begin
                next_state.driveLevel = regReq.wdata;
            end
            else if (regReq.addr == DRIVE_HIGH_STROBE_OFS)
            begin
                next_state.driveLevel = state.driveLevel | regReq.wdata;
            end
            else if (regReq.addr == DRIVE_LOW_STROBE_OFS)
            begin
                next_state.driveLevel = state.driveLevel & ~regReq.wdata;
            end
            else if (regReq.addr == LINE_ORIENTATION_WORD_OFS)
            begin
                next_state.orientation = regReq.wdata;
            end
            else if (regReq.addr == ENABLE_DRIVER_STROBE_OFS)
            begin
                next_state.orientation = state.orientation | regReq.wdata;
            end
            else if (regReq.addr == RELEASE_DRIVER_STROBE_OFS)
            begin
                next_state.orientation = state.orientation & ~regReq.wdata;
            end
            else if (setupHit)
            begin
                // same storage as the direction word
                next_state.orientation[setupIdx] = regReq.wdata[SETUP_DIR_BIT];
                next_state.inputDisc[setupIdx]   = regReq.wdata[SETUP_INPUT_BIT];
            end
            // unmapped writes are dropped
        end

        // reads: data stands only in the following cycle
        next_state.rdata = ZERO_WORD;
        if (regReq.rd)
        begin
            if (regReq.addr == DRIVE_LEVEL_WORD_OFS)
            begin
                next_state.rdata = state.driveLevel;
            end
            else if ((regReq.addr == DRIVE_HIGH_STROBE_OFS)
                  || (regReq.addr == DRIVE_LOW_STROBE_OFS))
            begin
                next_state.rdata = state.driveLevel;
            end
            else if (regReq.addr == SAMPLED_LEVELS_OFS)
            begin
                next_state.rdata = sampled;
            end
            else if ((regReq.addr == LINE_ORIENTATION_WORD_OFS)
                  || (regReq.addr == ENABLE_DRIVER_STROBE_OFS)
                  || (regReq.addr == RELEASE_DRIVER_STROBE_OFS))
            begin
                next_state.rdata = state.orientation;
            end
            else if (setupHit)
            begin
                next_state.rdata = setupRead;
            end
            // unmapped reads return zero
        end

        // pads follow the new register contents, one flop from outputs
        next_state.padOut = next_state.driveLevel;
        next_state.padOe  = next_state.orientation;
    end

    // single state register
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            state.driveLevel  <= DRIVE_LEVEL_RESET;
            state.orientation <= ORIENT_RESET;
            state.inputDisc   <= INPUT_DISC_RESET;
            state.syncA       <= ZERO_WORD;
            state.syncB       <= ZERO_WORD;
            state.padOut      <= DRIVE_LEVEL_RESET;
            state.padOe       <= ORIENT_RESET;
            state.rdata       <= ZERO_WORD;
        end
        else
        begin
            state <= next_state;
        end
    end

    // outputs straight from flops
    assign regRdata = state.rdata;
    assign padOut   = state.padOut;
    assign padOe    = state.padOe;

endmodule

`default_nettype wire

// ==== tb/gpio_port_properties.sv ====
// concurrent checks on the register side and the pad outputs
// assumes it is bound to the port top; one clock, async low reset
`timescale 1ns/100ps
`default_nettype none
module gpio_port_properties
    import gpio_port_pkg::*;
(
    input wire logic                     mclk,
    input wire logic                     resetn,
    input wire gpio_port_pkg::reg_req_t  regReq,
    input wire logic [31:0]              regRdata,
    input wire logic [31:0]              padIn,
    input wire logic [31:0]              padOut,
    input wire logic [31:0]              padOe
);
    wire logic [11:0] a = regReq.addr;  // short aliases keep lines narrow
    wire logic [31:0] d = regReq.wdata;
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);
    chk_set_raises: assert property (regReq.wr && a == 12'h0508
        |=> padOut == ($past(padOut) | $past(d))) else $error("drive set wrong");
    chk_clr_lowers: assert property (regReq.wr && a == 12'h050c
        |=> padOut == ($past(padOut) & ~$past(d))) else $error("drive clear wrong");
    chk_dir_sets: assert property (regReq.wr && a == 12'h0518
        |=> padOe == ($past(padOe) | $past(d))) else $error("dir set wrong");
    chk_dir_clears: assert property (regReq.wr && a == 12'h051c
        |=> padOe == ($past(padOe) & ~$past(d))) else $error("dir clear wrong");
    chk_level_reads: assert property (regReq.rd && a inside {12'h0504, 12'h0508, 12'h050c}
        |=> regRdata == $past(padOut)) else $error("level read wrong");
    chk_dir_reads: assert property (regReq.rd && a inside {12'h0514, 12'h0518, 12'h051c}
        |=> regRdata == $past(padOe)) else $error("dir read wrong");
    chk_word_replace: assert property (regReq.wr && a == 12'h0504
        |=> padOut == $past(d)) else $error("level write wrong");
    chk_dir_word: assert property (regReq.wr && a == 12'h0514
        |=> padOe == $past(d)) else $error("dir write wrong");
    chk_setup_shared: assert property (regReq.wr && a == 12'h0704
        |=> padOe[1] == $past(d[0])) else $error("setup dir not shared");
    // outputs move only on a write
    chk_idle_hold: assert property (!regReq.wr
        |=> $stable(padOut) && $stable(padOe)) else $error("pads moved idle");
endmodule
`default_nettype wire

// ==== tb/tb.sv ====
// register-level bench for the 32-pin port
// assumes the port and its package; no partner, bench drives pads
`timescale 1ns/100ps
`default_nettype none
module tb;
    import gpio_port_pkg::*;
    logic        mclk = 1'b0;
    logic        resetn = 1'b0;
    reg_req_t    regReq = '0;
    logic [31:0] regRdata, padOut, padOe;
    logic [31:0] padIn = 32'h0000_0000;
    int          failCount = 0;
    int          testsRun = 0;
    gpio_port_level_direction DUT (.mclk(mclk), .resetn(resetn), .regReq(regReq),
        .regRdata(regRdata), .padIn(padIn), .padOut(padOut), .padOe(padOe));
    initial forever #5 mclk = ~mclk;
    // one strobe cycle; results settled on return
    task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk) regReq <= '{a, d, w, !w};
        @(posedge mclk) regReq <= '{a, d, 1'b0, 1'b0};
        #1;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        testsRun++;
        if (g !== e)
        begin
            failCount++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] e);
        acc(1'b0, a, 32'h0000_0000);
        chk("regRdata", e, regRdata);
    endtask
    task automatic completeRun;
        $display("checks %0d mismatches %0d", testsRun, failCount);
        if (failCount == 0 && testsRun > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // hang guard, far beyond the roughly 50 cycles used
    initial
    begin
        #20000;
        failCount++;
        completeRun;
    end
    // main sequence
    initial
    begin
        repeat (10) @(posedge mclk);
        resetn <= 1'b1;
        chk("padOe", 32'h0000_0000, padOe);
        rdc(12'h0514, 32'h0000_0000);
        acc(1'b1, 12'h0504, 32'hA5A5_0F0F);
        chk("padOut", 32'hA5A5_0F0F, padOut);
        acc(1'b1, 12'h0508, 32'h0000_00F0);
        rdc(12'h0508, 32'hA5A5_0FFF);
        acc(1'b1, 12'h050c, 32'hA000_000F);
        rdc(12'h050c, 32'h05A5_0FF0);
        rdc(12'h0504, 32'h05A5_0FF0);
        acc(1'b1, 12'h0514, 32'h0000_FFFF);
        acc(1'b1, 12'h0518, 32'hFF00_0000);
        rdc(12'h0518, 32'hFF00_FFFF);
        acc(1'b1, 12'h051c, 32'h0000_00FF);
        rdc(12'h051c, 32'hFF00_FF00);
        acc(1'b1, 12'h0704, 32'h0000_0001);
        rdc(12'h0514, 32'hFF00_FF02);
        chk("padOe", 32'hFF00_FF02, padOe);
        padIn <= 32'h1234_5678;
        acc(1'b1, 12'h070c, 32'h0000_0002);
        rdc(12'h0510, 32'h1234_5670);
        acc(1'b1, 12'h0600, 32'hFFFF_FFFF);
        rdc(12'h0600, 32'h0000_0000);
        rdc(12'h0514, 32'hFF00_FF02);
        completeRun;
    end
endmodule
bind gpio_port_level_direction gpio_port_properties chk (.mclk(mclk), .resetn(resetn),
    .regReq(regReq), .regRdata(regRdata), .padIn(padIn), .padOut(padOut), .padOe(padOe));
`default_nettype wire
